// File: hdl/s2cfg_cfg.svh
// Offsets, field positions, reset values and timing counts of the stage-two config bank
`ifndef S2CFG_CFG_SVH
`define S2CFG_CFG_SVH
// Register indices as printed; byte address is four times the index
`define S2CFG_IDX_SHIFT_DELAY 8'h28
`define S2CFG_IDX_CH1_CUR 8'h29
`define S2CFG_IDX_TOPOLOGY 8'h2A
`define S2CFG_IDX_CH2_CUR 8'h2B
`define S2CFG_IDX_TIMEOUT 8'h2C
`define S2CFG_IDX_COEF 8'h2D
`define S2CFG_IDX_MIN_PERIOD 8'h2E
// Field positions
`define S2CFG_SHIFT_MSB 7
`define S2CFG_SHIFT_LSB 4
`define S2CFG_DLY_MSB 3
`define S2CFG_DLY_LSB 1
`define S2CFG_TOPBIT 0
`define S2CFG_TO_MSB 7
`define S2CFG_TO_LSB 6
// Reset values
`define S2CFG_RST_BYTE 8'h00
// Timing: delay step 50 ns, period step four of those, clock 50 ns
`define S2CFG_CLK_NS 50
`define S2CFG_STEP_NS 50
`define S2CFG_STEP_CYC ((`S2CFG_STEP_NS + `S2CFG_CLK_NS - 1) / `S2CFG_CLK_NS)
`define S2CFG_PERIOD_MULT 4
// Time-out limits in microseconds, codes 00 to 11
`define S2CFG_TO0_US 45000
`define S2CFG_TO1_US 70600
`define S2CFG_TO2_US 96200
`define S2CFG_TO3_US 121800
`define S2CFG_US_CYC(us) (((us) * 1000) / `S2CFG_CLK_NS)
`endif

// File: hdl/s2cfg_pkg.sv
// Types of the stage-two config bank
package s2cfg_pkg;
    typedef enum logic [1:0] {TOPO_BUCK, TOPO_TAP_UNITY, TOPO_TAP_N} s2cfg_topo_t;
    typedef struct packed {
        logic [8:0] ch1_target;
        logic [8:0] ch2_target;
        logic [3:0] tap_ratio;
        logic [7:0] coef_limit;
    } s2cfg_settings_t;
endpackage

// File: hdl/s2cfg_regs.sv
// Stage-two current configuration registers with AXI4-Lite slave and timing helpers
// Behaviour
// - Peak threshold is the 24-bit integrator shifted right by shift count, low 10 bits.
// - Channel 1 falling detect delayed by field times 50 ns after aux falls.
// - Channel 1 target is 9 bits: top bit in shift register bit 0, low byte.
// - Channel 2 target is 9 bits: top bit in topology register bit 0, low byte.
// - Topology 0 normal buck, 1 tapped unity as buck, 2-15 tapped ratio N.
// - Channel 1 rising detect delayed by rise field times 50 ns, values 0-7.
// - Coefficient register gives unsigned maximum integrator coefficient 0 to 255.
// - Minimum switching period equals setting times 4 times 50 ns.
`include "s2cfg_cfg.svh"
module s2cfg_regs #(
    parameter int unsigned TO0_CYC = `S2CFG_US_CYC(`S2CFG_TO0_US),
    parameter int unsigned TO1_CYC = `S2CFG_US_CYC(`S2CFG_TO1_US),
    parameter int unsigned TO2_CYC = `S2CFG_US_CYC(`S2CFG_TO2_US),
    parameter int unsigned TO3_CYC = `S2CFG_US_CYC(`S2CFG_TO3_US)
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_B,
    // AXI4-Lite write address
    input wire logic [9:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    // AXI4-Lite write data
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read address
    input wire logic [9:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    // AXI4-Lite read data
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Integrator and peak threshold
    input wire logic [23:0] INTEGRATOR_VALUE,
    output logic [9:0] PEAK_THRESHOLD,
    // Zero-current detection, channel 1
    input wire logic CH1_CYCLE,
    input wire logic ZCD_FALL_RAW,
    input wire logic ZCD_RISE_RAW,
    output logic ZCD_FALL_DELAYED,
    output logic ZCD_RISE_DELAYED,
    // Switching period supervision
    input wire logic SWITCH_START,
    output logic PERIOD_ALLOWED,
    output logic TIMEOUT_EXPIRED,
    // Settings to the stage logic
    output s2cfg_pkg::s2cfg_settings_t SETTINGS,
    output s2cfg_pkg::s2cfg_topo_t TOPOLOGY
);

    ////////////////////////////////////////////////////////////////////////
    // Register storage
    logic [7:0] regs_q [0:6];
    logic aw_full_q, w_full_q;
    logic [9:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;

    function automatic logic [3:0] decode(input logic [9:0] addr);
        logic [7:0] idx;
        idx = addr[9:2];
        if (addr[1:0] != 2'h0) begin
            decode = 4'hF;
        end else if (idx >= `S2CFG_IDX_SHIFT_DELAY && idx <= `S2CFG_IDX_MIN_PERIOD) begin
            decode = 4'(idx - `S2CFG_IDX_SHIFT_DELAY);
        end else begin
            decode = 4'hF;
        end
    endfunction

    function automatic logic [5:0] step_len(input logic [2:0] dly_field);
        step_len = 6'(dly_field * `S2CFG_STEP_CYC);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Write channel: address and data taken in either order
    assign S_AXI_AWREADY = !aw_full_q && !S_AXI_BVALID;
    assign S_AXI_WREADY = !w_full_q && !S_AXI_BVALID;

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= 10'h000;
        end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= S_AXI_AWADDR;
        end else if (aw_full_q && w_full_q) begin
            aw_full_q <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            w_full_q <= 1'b0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
        end else if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_full_q <= 1'b1;
            w_data_q <= S_AXI_WDATA;
            w_strb_q <= S_AXI_WSTRB;
        end else if (aw_full_q && w_full_q) begin
            w_full_q <= 1'b0;
        end
    end

    logic [3:0] wr_idx;
    assign wr_idx = decode(aw_addr_q);

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            for (int i = 0; i < 7; i++) begin
                regs_q[i] <= `S2CFG_RST_BYTE;
            end
        end else if (aw_full_q && w_full_q && wr_idx != 4'hF && w_strb_q[0]) begin
            regs_q[wr_idx[2:0]] <= w_data_q[7:0];
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            S_AXI_BVALID <= 1'b0;
        end else if (aw_full_q && w_full_q) begin
            S_AXI_BVALID <= 1'b1;
        end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            S_AXI_BRESP <= 2'h0;
        end else if (aw_full_q && w_full_q) begin
            S_AXI_BRESP <= (wr_idx == 4'hF) ? 2'h2 : 2'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel
    assign S_AXI_ARREADY = !S_AXI_RVALID;
    logic [3:0] rd_idx;
    assign rd_idx = decode(S_AXI_ARADDR);

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            S_AXI_RVALID <= 1'b0;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= 2'h0;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            if (rd_idx == 4'hF) begin
                S_AXI_RDATA <= 32'h00000000;
                S_AXI_RRESP <= 2'h2;
            end else if (rd_idx == 4'h4) begin
                S_AXI_RDATA <= {24'h000000, regs_q[4][7:6], TIMEOUT_EXPIRED, 5'h00};
                S_AXI_RRESP <= 2'h0;
            end else begin
                S_AXI_RDATA <= {24'h000000, regs_q[rd_idx[2:0]]};
                S_AXI_RRESP <= 2'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Field decode
    logic [3:0] shift_cnt;
    logic [2:0] fall_dly, rise_dly;
    logic [3:0] tap;
    logic [1:0] to_code;
    assign shift_cnt = regs_q[0][`S2CFG_SHIFT_MSB:`S2CFG_SHIFT_LSB];
    assign fall_dly = regs_q[0][`S2CFG_DLY_MSB:`S2CFG_DLY_LSB];
    assign tap = regs_q[2][`S2CFG_SHIFT_MSB:`S2CFG_SHIFT_LSB];
    assign rise_dly = regs_q[2][`S2CFG_DLY_MSB:`S2CFG_DLY_LSB];
    assign to_code = regs_q[4][`S2CFG_TO_MSB:`S2CFG_TO_LSB];

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            SETTINGS <= '0;
        end else begin
            SETTINGS.ch1_target <= {regs_q[0][`S2CFG_TOPBIT], regs_q[1]};
            SETTINGS.ch2_target <= {regs_q[2][`S2CFG_TOPBIT], regs_q[3]};
            SETTINGS.tap_ratio <= tap;
            SETTINGS.coef_limit <= regs_q[5];
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            TOPOLOGY <= s2cfg_pkg::TOPO_BUCK;
        end else begin
            case (tap)
                4'h0: TOPOLOGY <= s2cfg_pkg::TOPO_BUCK;
                4'h1: TOPOLOGY <= s2cfg_pkg::TOPO_TAP_UNITY;
                default: TOPOLOGY <= s2cfg_pkg::TOPO_TAP_N;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Peak threshold
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            PEAK_THRESHOLD <= 10'h000;
        end else begin
            PEAK_THRESHOLD <= 10'(INTEGRATOR_VALUE >> shift_cnt);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Zero-current detection delays, one step per delay unit
    logic [5:0] fall_cnt_q, rise_cnt_q;
    logic fall_busy_q, rise_busy_q;
    logic [5:0] fall_len, rise_len;
    logic fall_prev_q, rise_prev_q;
    logic fall_edge, rise_edge;
    assign fall_len = step_len(fall_dly);
    assign rise_len = step_len(rise_dly);
    // One event per crossing, so a held level cannot retrigger
    assign fall_edge = ZCD_FALL_RAW && !fall_prev_q;
    assign rise_edge = ZCD_RISE_RAW && !rise_prev_q;

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            fall_prev_q <= 1'b0;
            rise_prev_q <= 1'b0;
        end else begin
            fall_prev_q <= ZCD_FALL_RAW;
            rise_prev_q <= ZCD_RISE_RAW;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            fall_busy_q <= 1'b0;
            fall_cnt_q <= 6'h00;
            ZCD_FALL_DELAYED <= 1'b0;
        end else if (fall_edge && CH1_CYCLE && !fall_busy_q) begin
            fall_busy_q <= (fall_len != 6'h00);
            fall_cnt_q <= fall_len;
            ZCD_FALL_DELAYED <= (fall_len == 6'h00);
        end else if (fall_busy_q && fall_cnt_q == 6'h01) begin
            fall_busy_q <= 1'b0;
            fall_cnt_q <= 6'h00;
            ZCD_FALL_DELAYED <= 1'b1;
        end else begin
            fall_cnt_q <= fall_busy_q ? fall_cnt_q - 6'h01 : 6'h00;
            ZCD_FALL_DELAYED <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rise_busy_q <= 1'b0;
            rise_cnt_q <= 6'h00;
            ZCD_RISE_DELAYED <= 1'b0;
        end else if (rise_edge && CH1_CYCLE && !rise_busy_q) begin
            rise_busy_q <= (rise_len != 6'h00);
            rise_cnt_q <= rise_len;
            ZCD_RISE_DELAYED <= (rise_len == 6'h00);
        end else if (rise_busy_q && rise_cnt_q == 6'h01) begin
            rise_busy_q <= 1'b0;
            rise_cnt_q <= 6'h00;
            ZCD_RISE_DELAYED <= 1'b1;
        end else begin
            rise_cnt_q <= rise_busy_q ? rise_cnt_q - 6'h01 : 6'h00;
            ZCD_RISE_DELAYED <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Minimum period and time-out
    logic [11:0] per_cnt_q, per_cnt_d;
    logic [21:0] to_cnt_q;
    logic [11:0] min_per;
    logic [21:0] to_lim;
    assign min_per = 12'(regs_q[6] * `S2CFG_PERIOD_MULT * `S2CFG_STEP_CYC);

    always_comb begin
        case (to_code)
            2'h0: to_lim = 22'(TO0_CYC);
            2'h1: to_lim = 22'(TO1_CYC);
            2'h2: to_lim = 22'(TO2_CYC);
            default: to_lim = 22'(TO3_CYC);
        endcase
    end

    always_comb begin
        if (SWITCH_START) begin
            per_cnt_d = 12'h001;
        end else if (per_cnt_q != 12'hFFF) begin
            per_cnt_d = per_cnt_q + 12'h001;
        end else begin
            per_cnt_d = per_cnt_q;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            per_cnt_q <= 12'h000;
        end else begin
            per_cnt_q <= per_cnt_d;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            PERIOD_ALLOWED <= 1'b1;
        end else begin
            PERIOD_ALLOWED <= (per_cnt_d >= min_per);
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            to_cnt_q <= 22'h000000;
            TIMEOUT_EXPIRED <= 1'b0;
        end else if (SWITCH_START || to_cnt_q >= to_lim - 22'h000001) begin
            to_cnt_q <= 22'h000000;
            TIMEOUT_EXPIRED <= !SWITCH_START;
        end else begin
            to_cnt_q <= to_cnt_q + 22'h000001;
            TIMEOUT_EXPIRED <= 1'b0;
        end
    end

endmodule // s2cfg_regs

// File: verif/s2cfg_chk.sv
// Port checks on the stage-two config bank
module s2cfg_chk (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_B,
    // Register bus
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [9:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0] S_AXI_RRESP,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Timing outputs and settings
    input wire logic ZCD_FALL_DELAYED,
    input wire logic ZCD_RISE_DELAYED,
    input wire logic TIMEOUT_EXPIRED,
    input s2cfg_pkg::s2cfg_settings_t SETTINGS,
    input s2cfg_pkg::s2cfg_topo_t TOPOLOGY
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);
    ////////////////////////////////////////////////////////////////////////////
    a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
        && S_AXI_WREADY |-> ##2 S_AXI_BVALID) else $error("write answer late");
    a_bvalid_drop: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
        else $error("write answer stuck");
    a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read answer late");
    a_rvalid_drop: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
        else $error("read answer stuck");
    a_unmapped_read: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR > 10'h0B8
        |=> S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0) else $error("unmapped read");
    a_topo_decode: assert property (TOPOLOGY == (SETTINGS.tap_ratio == 4'h0 ? s2cfg_pkg::TOPO_BUCK
        : SETTINGS.tap_ratio == 4'h1 ? s2cfg_pkg::TOPO_TAP_UNITY : s2cfg_pkg::TOPO_TAP_N))
        else $error("topology decode");
    a_fall_pulse: assert property (ZCD_FALL_DELAYED |=> !ZCD_FALL_DELAYED)
        else $error("fall pulse too long");
    a_rise_pulse: assert property (ZCD_RISE_DELAYED |=> !ZCD_RISE_DELAYED)
        else $error("rise pulse too long");
    a_timeout_pulse: assert property (TIMEOUT_EXPIRED |=> !TIMEOUT_EXPIRED)
        else $error("timeout pulse too long");
    ////////////////////////////////////////////////////////////////////////////
    cover property (ZCD_FALL_DELAYED);
    cover property (TIMEOUT_EXPIRED);
    cover property (S_AXI_RVALID && S_AXI_RRESP == 2'h2);
endmodule // s2cfg_chk

// File: verif/test_second_stage_current_config_regs.sv
// Bench for the stage-two config bank
module test_second_stage_current_config_regs;
    timeunit 1ns;
    timeprecision 1ns;
    logic CORE_CLK = '0, RST_B = '0;
    logic [9:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
    logic S_AXI_AWVALID = '0, S_AXI_WVALID = '0, S_AXI_BREADY = '0;
    logic S_AXI_ARVALID = '0, S_AXI_RREADY = '0;
    logic [31:0] S_AXI_WDATA = '0, S_AXI_RDATA, rd;
    logic [3:0] S_AXI_WSTRB = 4'hF;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rsp;
    logic [23:0] INTEGRATOR_VALUE = '0;
    logic [9:0] PEAK_THRESHOLD;
    logic CH1_CYCLE = '0, ZCD_FALL_RAW = '0, ZCD_RISE_RAW = '0, SWITCH_START = '0;
    logic ZCD_FALL_DELAYED, ZCD_RISE_DELAYED, PERIOD_ALLOWED, TIMEOUT_EXPIRED;
    s2cfg_pkg::s2cfg_settings_t SETTINGS;
    s2cfg_pkg::s2cfg_topo_t TOPOLOGY;
    int errors = 0, total_checks = 0, n;
    always #25 CORE_CLK = ~CORE_CLK;
    s2cfg_regs #(.TO0_CYC(20), .TO1_CYC(30), .TO2_CYC(40), .TO3_CYC(50)) uut (.*);
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic a, w;
        a = 1'h1;
        w = 1'h1;
        @(posedge CORE_CLK);
        S_AXI_AWADDR <= {idx, 2'h0};
        S_AXI_WDATA <= d;
        S_AXI_AWVALID <= 1'h1;
        S_AXI_WVALID <= 1'h1;
        S_AXI_BREADY <= 1'h1;
        while (a || w) begin
            @(negedge CORE_CLK);
            a = a && !S_AXI_AWREADY;
            w = w && !S_AXI_WREADY;
            @(posedge CORE_CLK);
            S_AXI_AWVALID <= a;
            S_AXI_WVALID <= w;
        end
        while (!S_AXI_BVALID) @(negedge CORE_CLK);
        rsp = S_AXI_BRESP;
        @(posedge CORE_CLK);
        S_AXI_BREADY <= 1'h0;
        @(posedge CORE_CLK);
    endtask
    task automatic rd_reg(input logic [7:0] idx);
        @(posedge CORE_CLK);
        S_AXI_ARADDR <= {idx, 2'h0};
        S_AXI_ARVALID <= 1'h1;
        S_AXI_RREADY <= 1'h1;
        do @(negedge CORE_CLK); while (!S_AXI_ARREADY);
        @(posedge CORE_CLK);
        S_AXI_ARVALID <= 1'h0;
        do @(negedge CORE_CLK); while (!S_AXI_RVALID);
        rd = S_AXI_RDATA;
        rsp = S_AXI_RRESP;
        @(posedge CORE_CLK);
        S_AXI_RREADY <= 1'h0;
    endtask
    task automatic pulse(input int k);
        @(posedge CORE_CLK);
        ZCD_FALL_RAW <= (k == 0);
        ZCD_RISE_RAW <= (k == 1);
        SWITCH_START <= (k == 2);
        @(posedge CORE_CLK);
        ZCD_FALL_RAW <= 1'h0;
        ZCD_RISE_RAW <= 1'h0;
        SWITCH_START <= 1'h0;
    endtask
    task automatic count(input int k);
        n = 0;
        do begin
            @(negedge CORE_CLK);
            n++;
        end while (!(k == 0 ? ZCD_FALL_DELAYED : k == 1 ? ZCD_RISE_DELAYED
            : k == 2 ? PERIOD_ALLOWED : TIMEOUT_EXPIRED) && n < 60);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_bus;
        for (int i = 0; i < 7; i++) begin
            rd_reg(8'h28 + i[7:0]);
            chk(rd, 32'h0);
            chk({30'h0, rsp}, 32'h0);
        end
        rd_reg(8'h2F);
        chk({30'h0, rsp}, 32'h2);
        chk(rd, 32'h0);
        wr(8'h2F, 32'hFF);
        chk({30'h0, rsp}, 32'h2);
        S_AXI_WSTRB <= 4'hE;
        wr(8'h2D, 32'hFF);
        chk({30'h0, rsp}, 32'h0);
        S_AXI_WSTRB <= 4'hF;
        rd_reg(8'h2D);
        chk(rd, 32'h0);
    endtask
    task automatic t_fields;
        for (int v = 0; v < 16; v++) begin
            wr(8'h2A, {24'h0, v[3:0], 4'h0});
            chk({28'h0, SETTINGS.tap_ratio}, v);
            chk({30'h0, TOPOLOGY}, v < 2 ? v : 2);
        end
        wr(8'h28, 32'h01);
        wr(8'h29, 32'hA5A5A5FF);
        wr(8'h2A, 32'h01);
        wr(8'h2B, 32'h00);
        wr(8'h2D, 32'h7E);
        chk({23'h0, SETTINGS.ch1_target}, 32'h1FF);
        chk({23'h0, SETTINGS.ch2_target}, 32'h100);
        chk({24'h0, SETTINGS.coef_limit}, 32'h7E);
        rd_reg(8'h29);
        chk(rd, 32'hFF);
    endtask
    task automatic t_peak;
        INTEGRATOR_VALUE <= 24'hABCDEF;
        for (int s = 0; s < 16; s++) begin
            wr(8'h28, {24'h0, s[3:0], 4'h0});
            chk({22'h0, PEAK_THRESHOLD}, (32'hABCDEF >> s) & 32'h3FF);
        end
    endtask
    task automatic t_zcd;
        CH1_CYCLE <= 1'h1;
        for (int d = 0; d < 8; d += 7) begin
            wr(8'h28, {28'h0, d[2:0], 1'h0});
            wr(8'h2A, {28'h0, d[2:0], 1'h0});
            for (int k = 0; k < 2; k++) begin
                pulse(k);
                count(k);
                chk({31'h0, n >= d + 1 && n <= d + 2}, 32'h1);
            end
        end
        @(posedge CORE_CLK);
        CH1_CYCLE <= 1'h0;
        pulse(0);
        count(0);
        chk(n, 32'h3C);
    endtask
    task automatic t_timing;
        wr(8'h2E, 32'h03);
        pulse(2);
        count(2);
        chk({31'h0, n >= 12 && n <= 14}, 32'h1);
        for (int c = 0; c < 4; c++) begin
            wr(8'h2C, {24'h0, c[1:0], 6'h0});
            rd_reg(8'h2C);
            chk(rd & 32'hC0, {24'h0, c[1:0], 6'h0});
            pulse(2);
            count(3);
            chk({31'h0, n >= 20 + 10 * c && n <= 22 + 10 * c}, 32'h1);
        end
    endtask
    task automatic end_sim;
        $display("errors=%0d checks=%0d", errors, total_checks);
        if (errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge CORE_CLK);
        RST_B <= 1'h1;
        t_bus;
        t_fields;
        t_peak;
        t_zcd;
        t_timing;
        end_sim;
    end
    initial begin
        repeat (5000) @(posedge CORE_CLK);
        errors++;
        end_sim;
    end
endmodule // test_second_stage_current_config_regs
bind s2cfg_regs s2cfg_chk chk_i (.*);
